// *** rtl/twb_pkg.sv ***
package twb_pkg;

  // Timing of the local bus clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_LOW_NS = 5000;
  localparam int SCL_HIGH_NS = 5000;
  localparam int COND_HOLD_NS = 5000;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] LOW_CYC =
    CNT_W'((SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HIGH_CYC =
    CNT_W'((SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] COND_CYC =
    CNT_W'((COND_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Packet framing
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] PKT_BITS = 4'h9;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [3:0] RSVD_PREFIX = 4'hF;
  localparam logic [7:0] RD_FILL = 8'hFF;

  // Reset values
  localparam logic [1:0] STEP_RST = 2'h0;
  localparam logic [3:0] BIT_RST = 4'h0;
  localparam logic [8:0] TX_RST = 9'h1FF;
  localparam logic [7:0] RX_RST = 8'h00;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_START = 7'h02,
    ST_BIT_LOW = 7'h04,
    ST_BIT_HIGH = 7'h08,
    ST_HOLD = 7'h10,
    ST_STOP = 7'h20,
    ST_LISTEN = 7'h40
  } twb_state_t;

endpackage

// *** rtl/twb_master.sv ***
`timescale 1ns/1ps

module twb_master (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Power control
  input wire logic link_enable,
  output logic serial_bus_power_gate,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_nack,
  input wire logic [7:0] cmd_wdata,
  // Response port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  output logic rsp_err,
  output logic arb_lost,
  output logic addressed,
  output logic bus_busy,
  // Own slave identity
  input wire logic [6:0] own_addr,
  input wire logic gc_enable,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  function automatic logic [twb_pkg::CNT_W-1:0] dec_cnt(
    input logic [twb_pkg::CNT_W-1:0] v);
    dec_cnt = (v == '0) ? v : v - 1'b1;
  endfunction

  twb_pkg::twb_state_t state_reg, state_next;
  logic [1:0] step_reg, step_next;
  logic [twb_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [8:0] tx_reg, tx_next;
  logic [7:0] rx_reg, rx_next;
  logic scl_drv_reg, scl_drv_next;
  logic sda_drv_reg, sda_drv_next;
  logic stop_pend_reg, stop_pend_next;
  logic addr_pkt_reg, addr_pkt_next;
  logic rd_reg, rd_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [7:0] rsp_data_reg, rsp_data_next;
  logic rsp_nack_reg, rsp_nack_next;
  logic rsp_err_reg, rsp_err_next;
  logic arb_lost_reg, arb_lost_next;
  logic addressed_reg, addressed_next;
  logic busy_reg;
  logic pgate_reg;
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;

  // Line observation
  wire scl_q = scl_s2_reg;
  wire sda_q = sda_s2_reg;
  wire scl_rise = scl_q & ~scl_d_reg;
  wire scl_fall = ~scl_q & scl_d_reg;
  wire start_det = scl_q & scl_d_reg & sda_d_reg & ~sda_q;
  wire stop_det = scl_q & scl_d_reg & ~sda_d_reg & sda_q;
  wire cnt_zero = (cnt_reg == '0);
  wire own_ok = (own_addr[6:3] != twb_pkg::RSVD_PREFIX);
  wire own_match = own_ok & (rx_reg[7:1] == own_addr);
  wire gc_match = gc_enable & ~rx_reg[0]
    & (rx_reg[7:1] == twb_pkg::GCALL_ADDR);
  wire addr_match = addr_pkt_reg & (own_match | gc_match);
  wire gc_read = (cmd_wdata[7:1] == twb_pkg::GCALL_ADDR) & cmd_wdata[0];
  wire rsvd_addr = (cmd_wdata[7:4] == twb_pkg::RSVD_PREFIX);
  wire bad_addr = cmd_start & (gc_read | rsvd_addr);
  wire in_idle = (state_reg == twb_pkg::ST_IDLE);
  wire in_hold = (state_reg == twb_pkg::ST_HOLD);
  wire powered = ~pgate_reg;
  assign cmd_ready = powered
    & ((in_idle & ~(cmd_start & busy_reg)) | in_hold);
  wire cmd_fire = cmd_valid & cmd_ready;
  wire [8:0] cmd_tx = (cmd_read & ~cmd_start)
    ? {twb_pkg::RD_FILL, cmd_nack} : {cmd_wdata, 1'b1};
  wire last_bit = (bit_reg == twb_pkg::DATA_BITS);
  wire lost = ~rd_reg & ~sda_drv_reg & ~sda_q
    & (bit_reg < twb_pkg::DATA_BITS);

  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    cnt_next = dec_cnt(cnt_reg);
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    scl_drv_next = scl_drv_reg;
    sda_drv_next = sda_drv_reg;
    stop_pend_next = stop_pend_reg;
    addr_pkt_next = addr_pkt_reg;
    rd_next = rd_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    rsp_nack_next = rsp_nack_reg;
    rsp_err_next = rsp_err_reg;
    arb_lost_next = 1'b0;
    addressed_next = 1'b0;
    case (state_reg)
      twb_pkg::ST_IDLE: begin
        scl_drv_next = 1'b0;
        sda_drv_next = 1'b0;
        if (cmd_fire) begin
          if (~cmd_start | bad_addr) begin
            rsp_valid_next = 1'b1;
            rsp_err_next = 1'b1;
          end else begin
            state_next = twb_pkg::ST_START;
            step_next = twb_pkg::STEP_RST;
            cnt_next = twb_pkg::COND_CYC;
          end
        end
      end
      twb_pkg::ST_HOLD: begin
        scl_drv_next = 1'b1;
        if (cmd_fire) begin
          if (bad_addr) begin
            rsp_valid_next = 1'b1;
            rsp_err_next = 1'b1;
          end else if (cmd_start) begin
            state_next = twb_pkg::ST_START;
            step_next = twb_pkg::STEP_RST;
            cnt_next = twb_pkg::COND_CYC;
          end else begin
            state_next = twb_pkg::ST_BIT_LOW;
            cnt_next = twb_pkg::LOW_CYC;
            bit_next = twb_pkg::BIT_RST;
          end
        end
      end
      twb_pkg::ST_START: begin
        case (step_reg)
          2'h0: begin
            sda_drv_next = 1'b0;
            if (cnt_zero) begin
              scl_drv_next = 1'b0;
              step_next = 2'h1;
              cnt_next = twb_pkg::COND_CYC;
            end
          end
          2'h1: begin
            if (~scl_q) begin
              cnt_next = twb_pkg::COND_CYC;
            end else if (cnt_zero) begin
              sda_drv_next = 1'b1;
              step_next = 2'h2;
              cnt_next = twb_pkg::COND_CYC;
            end
          end
          default: begin
            if (cnt_zero) begin
              scl_drv_next = 1'b1;
              state_next = twb_pkg::ST_BIT_LOW;
              cnt_next = twb_pkg::LOW_CYC;
              bit_next = twb_pkg::BIT_RST;
            end
          end
        endcase
      end
      twb_pkg::ST_BIT_LOW: begin
        sda_drv_next = ~tx_reg[8];
        if (cnt_zero) begin
          scl_drv_next = 1'b0;
          state_next = twb_pkg::ST_BIT_HIGH;
          step_next = twb_pkg::STEP_RST;
        end
      end
      twb_pkg::ST_BIT_HIGH: begin
        if (step_reg == 2'h0) begin
          if (scl_q) begin
            step_next = 2'h1;
            cnt_next = twb_pkg::HIGH_CYC;
            if (last_bit) begin
              rsp_nack_next = sda_q;
            end else begin
              rx_next = {rx_reg[6:0], sda_q};
            end
            if (lost) begin
              sda_drv_next = 1'b0;
              arb_lost_next = 1'b1;
              bit_next = bit_reg + 1'b1;
              state_next = twb_pkg::ST_LISTEN;
            end
          end
        end else if (cnt_zero | ~scl_q) begin
          scl_drv_next = 1'b1;
          tx_next = {tx_reg[7:0], 1'b1};
          bit_next = bit_reg + 1'b1;
          if (last_bit) begin
            rsp_valid_next = 1'b1;
            rsp_data_next = rx_reg;
            rsp_err_next = 1'b0;
            if (stop_pend_reg | (addr_pkt_reg & rsp_nack_reg)) begin
              state_next = twb_pkg::ST_STOP;
              step_next = twb_pkg::STEP_RST;
              cnt_next = twb_pkg::COND_CYC;
            end else begin
              state_next = twb_pkg::ST_HOLD;
            end
          end else begin
            state_next = twb_pkg::ST_BIT_LOW;
            cnt_next = twb_pkg::LOW_CYC;
          end
        end
      end
      twb_pkg::ST_STOP: begin
        if (step_reg == 2'h0) begin
          sda_drv_next = 1'b1;
          if (cnt_zero) begin
            scl_drv_next = 1'b0;
            step_next = 2'h1;
            cnt_next = twb_pkg::COND_CYC;
          end
        end else if (~scl_q) begin
          cnt_next = twb_pkg::COND_CYC;
        end else if (cnt_zero) begin
          sda_drv_next = 1'b0;
          state_next = twb_pkg::ST_IDLE;
        end
      end
      twb_pkg::ST_LISTEN: begin
        scl_drv_next = 1'b0;
        if (start_det | stop_det) begin
          sda_drv_next = 1'b0;
          state_next = twb_pkg::ST_IDLE;
        end else if (scl_rise & (bit_reg < twb_pkg::DATA_BITS)) begin
          rx_next = {rx_reg[6:0], sda_q};
          bit_next = bit_reg + 1'b1;
        end else if (scl_fall & last_bit) begin
          if (addr_match) begin
            sda_drv_next = 1'b1;
            addressed_next = 1'b1;
            bit_next = twb_pkg::PKT_BITS;
          end else begin
            state_next = twb_pkg::ST_IDLE;
          end
        end else if (scl_fall & (bit_reg == twb_pkg::PKT_BITS)) begin
          sda_drv_next = 1'b0;
          state_next = twb_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = twb_pkg::ST_IDLE;
        scl_drv_next = 1'b0;
        sda_drv_next = 1'b0;
      end
    endcase
    if (cmd_fire & ~bad_addr & (cmd_start | in_hold)) begin
      tx_next = cmd_tx;
      rd_next = cmd_read & ~cmd_start;
      stop_pend_next = cmd_stop;
      addr_pkt_next = cmd_start;
    end
  end

  // Pin synchronisers and line history
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (ce) begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
    end
  end

  // Bus busy and power gate
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
      pgate_reg <= 1'b1;
    end else if (ce) begin
      pgate_reg <= ~link_enable;
      if (start_det) begin
        busy_reg <= 1'b1;
      end else if (stop_det) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Controller state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= twb_pkg::ST_IDLE;
      step_reg <= twb_pkg::STEP_RST;
      cnt_reg <= '0;
      bit_reg <= twb_pkg::BIT_RST;
      tx_reg <= twb_pkg::TX_RST;
      rx_reg <= twb_pkg::RX_RST;
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      stop_pend_reg <= 1'b0;
      addr_pkt_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      scl_drv_reg <= scl_drv_next;
      sda_drv_reg <= sda_drv_next;
      stop_pend_reg <= stop_pend_next;
      addr_pkt_reg <= addr_pkt_next;
      rd_reg <= rd_next;
    end
  end

  // Response registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= twb_pkg::RX_RST;
      rsp_nack_reg <= 1'b0;
      rsp_err_reg <= 1'b0;
      arb_lost_reg <= 1'b0;
      addressed_reg <= 1'b0;
    end else if (ce) begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      rsp_nack_reg <= rsp_nack_next;
      rsp_err_reg <= rsp_err_next;
      arb_lost_reg <= arb_lost_next;
      addressed_reg <= addressed_next;
    end
  end

  // Open-drain pins and module outputs
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_drv_reg;
  assign sda_oe = sda_drv_reg;
  assign serial_bus_power_gate = pgate_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_nack = rsp_nack_reg;
  assign rsp_err = rsp_err_reg;
  assign arb_lost = arb_lost_reg;
  assign addressed = addressed_reg;
  assign bus_busy = busy_reg;

endmodule // twb_master

// *** verif/twb_master_sva.sv ***
`timescale 1ns/1ps
module twb_master_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Power, commands, responses and bus state
  input wire logic link_enable,
  input wire logic serial_bus_power_gate,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic bus_busy,
  // Bus pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic [11:0] hi_cnt;
  logic [7:0] rise_cnt;
  logic scl_q;
  wire take = cmd_valid && cmd_ready;
  wire bad = cmd_wdata[7:4] == 4'hF || cmd_wdata == 8'h01;
  // Clock high time and clock rises since start
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt <= 12'h000;
      rise_cnt <= 8'h00;
      scl_q <= 1'b1;
    end else begin
      hi_cnt <= scl_in ? hi_cnt + {11'h000, ~&hi_cnt} : 12'h000;
      rise_cnt <= !bus_busy ? 8'h00 : rise_cnt + {7'h00, scl_in && !scl_q};
      scl_q <= scl_in;
    end
  end
  drive_low_a: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  gate_follow_a: assert property (ce |=>
    serial_bus_power_gate == !$past(link_enable)) else $error("gate late");
  gate_block_a: assert property (serial_bus_power_gate |->
    !cmd_ready) else $error("ready while unpowered");
  refuse_cmd_a: assert property (
    take && !bus_busy && (!cmd_start || bad)
    |=> rsp_valid && rsp_err && !sda_oe && !scl_oe) else $error("not refused");
  start_busy_a: assert property (
    $rose(sda_oe) && scl_in && !bus_busy |-> ##[1:6] bus_busy)
    else $error("start not seen");
  stop_idle_a: assert property (
    bus_busy && scl_in && scl_q && $rose(sda_in) |-> ##[1:6] !bus_busy)
    else $error("stop not seen");
  start_own_a: assert property (bus_busy && take && cmd_start |->
    scl_oe) else $error("start on busy bus");
  high_len_a: assert property (
    $rose(scl_oe) && $past(scl_in) |-> $past(hi_cnt) >= twb_pkg::HIGH_CYC)
    else $error("high phase short");
  pkt_len_a: assert property (
    rsp_valid && !rsp_err |-> rise_cnt != 8'h00 && rise_cnt % 8'h09 == 8'h00)
    else $error("packet not nine clocks");
  refuse_c: cover property (rsp_valid && rsp_err);
  done_c: cover property (rsp_valid && !rsp_err);
  stretch_c: cover property (bus_busy && !scl_oe && !scl_in);
endmodule // twb_master_sva

bind twb_master twb_master_sva chk (.ref_clk, .rst_b, .ce, .link_enable,
  .serial_bus_power_gate, .cmd_valid, .cmd_ready, .cmd_start, .cmd_wdata,
  .rsp_valid, .rsp_err, .bus_busy, .scl_in, .scl_out, .scl_oe, .sda_in,
  .sda_out, .sda_oe);

// *** verif/twb_slave_model.sv ***
`timescale 1ns/1ps
module twb_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // Link clock and control
  input wire logic lclk,
  input wire logic stretch,
  // Bus lines and pulls
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull = 1'b0,
  output logic sda_pull = 1'b0,
  // Bytes seen
  output logic [7:0] addr_seen = 8'h00,
  output logic [7:0] data_seen = 8'h00
);
  localparam logic [7:0] RD_BYTE = 8'hA5;
  logic [7:0] sh = 8'h00;
  logic [3:0] n = 4'h0;
  logic adr = 1'b0;
  logic rd = 1'b0;
  logic hit = 1'b0;
  always @(negedge sda) begin
    if (scl) begin
      n = 4'h0;
      adr = 1'b1;
      hit = 1'b0;
    end
  end
  // Bits taken at the clock rise, MSB first
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    n = n + 4'h1;
    if (n == 4'h9 && !adr && rd && sda) hit = 1'b0;
  end
  // Pulls only, changed while clock low
  always @(negedge scl) begin
    if (n == 4'h9) begin
      n = 4'h0;
      adr = 1'b0;
    end
    if (n == 4'h8 && adr) begin
      addr_seen = sh;
      rd = sh[0];
      hit = sh[7:1] == ADDR && sh[7:4] != 4'hF;
      sda_pull = hit;
    end else if (n == 4'h8) begin
      data_seen = rd ? data_seen : sh;
      sda_pull = hit && !rd;
    end else begin
      sda_pull = hit && rd && !adr && !RD_BYTE[3'h7 - n[2:0]];
    end
    if (n == 4'h0 && stretch) begin
      scl_pull = 1'b1;
      repeat (48) @(posedge lclk);
      scl_pull = 1'b0;
    end
  end
endmodule // twb_slave_model

// *** verif/two_wire_bus_protocol_bench.sv ***
`timescale 1ns/1ps
module two_wire_bus_protocol_bench;
  typedef struct packed {
    logic st;
    logic [7:0] wd;
    logic [1:0] ex;
  } twb_row_t;
  localparam twb_row_t ROWS [4] = '{'{1'b1, 8'hF0, 2'h3},
    '{1'b1, 8'hFF, 2'h3}, '{1'b1, 8'h01, 2'h3}, '{1'b0, 8'h55, 2'h3}};
  logic ref_clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_b = 1'b0;
  logic link_enable = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_start = 1'b0;
  logic cmd_stop = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_nack = 1'b0;
  logic [7:0] cmd_wdata = 8'h00;
  logic p_stretch = 1'b0;
  logic p_jam = 1'b0;
  logic ce = 1'b1;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  logic cmd_ready, rsp_valid, rsp_nack, rsp_err, arb_lost, addressed;
  logic bus_busy, serial_bus_power_gate, scl_out, scl_oe, sda_out, sda_oe;
  logic p_scl, p_sda;
  logic [7:0] rsp_data, p_addr, p_data;
  wire scl = !(scl_oe || p_scl);
  wire sda = !(sda_oe || p_sda || p_jam);
  always #5 ref_clk = ~ref_clk;
  initial #3.3 forever #62.5 lclk = ~lclk;
  twb_master uut (.ref_clk, .rst_b, .ce, .link_enable,
    .serial_bus_power_gate, .cmd_valid, .cmd_ready, .cmd_start, .cmd_stop,
    .cmd_read, .cmd_nack, .cmd_wdata, .rsp_valid, .rsp_data, .rsp_nack,
    .rsp_err, .arb_lost, .addressed, .bus_busy, .own_addr(7'h3C),
    .gc_enable(1'b0), .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda),
    .sda_out, .sda_oe);
  twb_slave_model #(.ADDR(7'h2A)) peer (.lclk, .stretch(p_stretch), .scl,
    .sda, .scl_pull(p_scl), .sda_pull(p_sda), .addr_seen(p_addr),
    .data_seen(p_data));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic st, input logic sp, input logic rd,
    input logic nk, input logic [7:0] wd);
    int i;
    cmd_start = st;
    cmd_stop = sp;
    cmd_read = rd;
    cmd_nack = nk;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    i = 0;
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1 && i < 2000) begin
      @(negedge ref_clk);
      i++;
    end
    if (i >= 2000) error_cnt++;
    @(posedge ref_clk);
    #1 cmd_valid = 1'b0;
  endtask
  task automatic wait_on(input logic want_rsp);
    int i;
    i = 0;
    while ((want_rsp ? rsp_valid !== 1'b1 : bus_busy !== 1'b0) && i < 30000)
    begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    if (i >= 30000) error_cnt++;
  endtask
  task automatic wrap_up;
    $display("mismatches %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    chk({5'h00, serial_bus_power_gate, cmd_ready, sda_oe}, 8'h04);
    rst_b = 1'b1;
    link_enable = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({7'h00, serial_bus_power_gate}, 8'h00);
    $display("test reset done");
    foreach (ROWS[k]) begin
      send(ROWS[k].st, 1'b0, 1'b0, 1'b0, ROWS[k].wd);
      chk({6'h00, rsp_valid, rsp_err}, {6'h00, ROWS[k].ex});
      chk({6'h00, bus_busy, sda_oe}, 8'h00);
      @(posedge ref_clk);
      #1;
    end
    $display("test refusals done");
    send(1'b1, 1'b0, 1'b0, 1'b0, 8'h54);
    wait_on(1'b1);
    chk({7'h00, rsp_nack}, 8'h00);
    chk(p_addr, 8'h54);
    send(1'b0, 1'b1, 1'b0, 1'b0, 8'hC3);
    wait_on(1'b1);
    chk({7'h00, rsp_nack}, 8'h00);
    chk(p_data, 8'hC3);
    chk(rsp_data, 8'hC3);
    wait_on(1'b0);
    chk({7'h00, bus_busy}, 8'h00);
    $display("test write done");
    send(1'b1, 1'b0, 1'b0, 1'b0, 8'h22);
    wait_on(1'b1);
    chk({7'h00, rsp_nack}, 8'h01);
    wait_on(1'b0);
    chk({7'h00, bus_busy}, 8'h00);
    $display("test address nack done");
    send(1'b1, 1'b0, 1'b0, 1'b0, 8'h80);
    while (sda_oe !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    p_jam = 1'b1;
    while (arb_lost !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    chk({5'h00, arb_lost, scl_oe, sda_oe}, 8'h04);
    p_jam = 1'b0;
    wait_on(1'b0);
    chk({6'h00, bus_busy, addressed}, 8'h00);
    $display("test arbitration done");
    p_stretch = 1'b1;
    send(1'b1, 1'b0, 1'b0, 1'b0, 8'h55);
    wait_on(1'b1);
    chk({7'h00, rsp_nack}, 8'h00);
    send(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
    wait_on(1'b1);
    chk(rsp_data, 8'hA5);
    chk({7'h00, rsp_nack}, 8'h01);
    wait_on(1'b0);
    p_stretch = 1'b0;
    $display("test stretched read done");
    ce = 1'b0;
    link_enable = 1'b0;
    cmd_start = 1'b1;
    cmd_wdata = 8'h54;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({7'h00, serial_bus_power_gate}, 8'h00);
    ce = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({6'h00, serial_bus_power_gate, cmd_ready}, 8'h02);
    $display("test power gate done");
    wrap_up;
  end
endmodule // two_wire_bus_protocol_bench
